// [common/cst_pkg.sv]
// Constants, register map and types for the calibration store and trim registers
package cst_pkg;

   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 32;
   localparam int IDX_W      = 10;
   localparam int CAL_WORDS  = 673;
   localparam int FIFO_DEPTH = 4;
   localparam int REF_W      = 4;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_PORT_EN  = 10'h070;
   localparam logic [9:0] IDX_CAL_PORT = 10'h071;
   localparam logic [9:0] IDX_STATUS   = 10'h072;
   localparam logic [9:0] IDX_GAIN_A   = 10'h07a;
   localparam logic [9:0] IDX_GAIN_B   = 10'h07b;
   localparam logic [9:0] IDX_REF      = 10'h07c;

   // Field positions
   localparam int EN_BIT        = 0;
   localparam int ST_INDEX_LSB  = 0;
   localparam int ST_HALTED_BIT = 16;
   localparam int ST_VIOL_BIT   = 17;
   localparam int ST_EMPTY_BIT  = 18;

   // Reset values and last word index
   localparam logic             PORT_EN_RST = 1'b0;
   localparam logic [IDX_W-1:0] INDEX_RST   = 10'h000;
   localparam logic [IDX_W-1:0] INDEX_LAST  = 10'h2a0;
   localparam logic [31:0]      RDATA_RST   = 32'h0000_0000;

   typedef struct packed {
      logic [IDX_W-1:0] index;
      logic [7:0]       data;
   } cst_word_s;

   typedef struct packed {
      logic [7:0]       gain_a;
      logic [7:0]       gain_b;
      logic [REF_W-1:0] ref_adj;
   } cst_trim_s;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_WAIT_RD = 2'b01,
      ST_DONE    = 2'b10
   } cst_state_e;

endpackage

// [src/cst_calib_regs.sv]
// APB register bank: calibration word port, gain and reference trims
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] Data port works only while enable set
// [RULE_02] Host sets enable before port accesses
// [RULE_03] 673 reads return successive calibration words
// [RULE_04] 673 writes load successive vector positions
// [RULE_05] Streamed accesses keep targeting the port
// [RULE_06] Host avoids port while calibration running
// [RULE_07] Host always completes all 673 accesses
// [RULE_08] Input A gain trim, fuse reset, RW
// [RULE_09] Input B gain trim, fuse reset, RW
// [RULE_10] Full-scale changes use range setting instead
// [RULE_11] Four-bit reference trim, upper bits reserved
// [RULE_12] Word index restarts on enable, advances
//
// Implementation choice: register access over APB.
module cst_calib_regs
   import cst_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic                      ce,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [cst_pkg::ADDR_W-1:0] paddr,
   input  wire logic [cst_pkg::DATA_W-1:0] pwdata,
   output logic [cst_pkg::DATA_W-1:0]      prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire cst_pkg::cst_trim_s        fuse_trim,
   output cst_pkg::cst_trim_s             trim_out,
   input  wire logic                      calibration_halted_flag,
   output logic                           cal_word_valid,
   input  wire logic                      cal_word_ready,
   output cst_pkg::cst_word_s             cal_word,
   output logic                           cal_rd_req,
   output logic [cst_pkg::IDX_W-1:0]       cal_rd_index,
   input  wire logic                      cal_rd_valid,
   input  wire logic [7:0]                cal_rd_data
);
   import cst_pkg::*;

   function automatic logic f_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
      f_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // State
   cst_state_e       state_ff;
   cst_state_e       nxt_state;
   logic             port_en_ff;
   logic [IDX_W-1:0] index_ff;
   logic [IDX_W-1:0] nxt_index;
   logic             viol_ff;
   logic [31:0]      prdata_ff;
   logic [31:0]      nxt_prdata;
   cst_trim_s        trim_ff;

   //////////////////////////////////////////////////////////////////////////
   // Address decode
   wire hit_en     = f_hit(paddr, IDX_PORT_EN);
   wire hit_cal    = f_hit(paddr, IDX_CAL_PORT);
   wire hit_status = f_hit(paddr, IDX_STATUS);
   wire hit_gain_a = f_hit(paddr, IDX_GAIN_A);
   wire hit_gain_b = f_hit(paddr, IDX_GAIN_B);
   wire hit_ref    = f_hit(paddr, IDX_REF);
   wire mapped     = hit_en | hit_cal | hit_status | hit_gain_a | hit_gain_b | hit_ref;

   // Port address reaches the vector only while port enable is set, streamed or not
   wire cal_live   = hit_cal & port_en_ff; // RULE_01 RULE_05
   wire start_rd   = cal_live & ~pwrite; // RULE_03
   wire start_wr   = cal_live & pwrite; // RULE_04

   wire fifo_in_ready;
   wire fifo_empty_n;
   wire [$bits(cst_word_s)-1:0] fifo_out;

   //////////////////////////////////////////////////////////////////////////
   // Transfer completion
   wire in_done    = (state_ff == ST_DONE);
   assign pready   = ce & psel & penable & in_done;
   assign pslverr  = pready & ~mapped;
   wire xfer_done  = pready;
   wire wr_done    = xfer_done & pwrite & mapped;
   wire cal_done   = xfer_done & cal_live;
   wire cal_wr     = cal_done & pwrite;
   wire en_set     = wr_done & hit_en & pwdata[EN_BIT];

   //////////////////////////////////////////////////////////////////////////
   // Read data selection
   wire [31:0] st_word = (32'(index_ff) << ST_INDEX_LSB)
                       | (32'(calibration_halted_flag) << ST_HALTED_BIT)
                       | (32'(viol_ff) << ST_VIOL_BIT)
                       | (32'(!fifo_empty_n) << ST_EMPTY_BIT);
   wire [31:0] rd_en     = hit_en ? 32'(port_en_ff) : 32'h0000_0000;
   wire [31:0] rd_st     = hit_status ? st_word : 32'h0000_0000;
   wire [31:0] rd_gain_a = hit_gain_a ? 32'(trim_ff.gain_a) : 32'h0000_0000; // RULE_08
   wire [31:0] rd_gain_b = hit_gain_b ? 32'(trim_ff.gain_b) : 32'h0000_0000; // RULE_09
   wire [31:0] rd_ref    = hit_ref ? 32'(trim_ff.ref_adj) : 32'h0000_0000; // RULE_11
   wire [31:0] rd_mux    = rd_en | rd_st | rd_gain_a | rd_gain_b | rd_ref;

   //////////////////////////////////////////////////////////////////////////
   // Access sequencer
   always_comb begin
      nxt_state  = state_ff;
      nxt_prdata = prdata_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (psel) begin
               if (start_rd) begin
                  nxt_state = ST_WAIT_RD; // RULE_03
               end else if (!start_wr || fifo_in_ready) begin
                  // Disabled port falls through here and reads zero
                  nxt_state  = ST_DONE; // RULE_01
                  nxt_prdata = pwrite ? RDATA_RST : rd_mux;
               end
            end
         end
         ST_WAIT_RD: begin
            if (cal_rd_valid) begin
               nxt_state  = ST_DONE; // RULE_03
               nxt_prdata = 32'(cal_rd_data);
            end
         end
         ST_DONE: begin
            if (xfer_done) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff  <= ST_IDLE;
         prdata_ff <= RDATA_RST;
      end else if (ce) begin
         state_ff  <= nxt_state;
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata       = prdata_ff;
   assign cal_rd_req   = (state_ff == ST_WAIT_RD);
   assign cal_rd_index = index_ff;

   //////////////////////////////////////////////////////////////////////////
   // Port enable, word index and misuse flag
   // Index wraps after the last word so a new pass starts cleanly
   assign nxt_index = en_set ? INDEX_RST : // RULE_12
                      !cal_done ? index_ff :
                      (index_ff == INDEX_LAST) ? INDEX_RST : // RULE_07
                      IDX_W'(index_ff + 1'b1); // RULE_12

   // Access during running calibration: set wins over clear
   wire viol_set = cal_done & ~calibration_halted_flag; // RULE_06
   wire nxt_viol = viol_set | (viol_ff & ~en_set);

   always_ff @(posedge clk) begin
      if (srst) begin
         port_en_ff <= PORT_EN_RST;
         index_ff   <= INDEX_RST;
         viol_ff    <= 1'b0;
      end else if (ce) begin
         if (wr_done && hit_en) begin
            port_en_ff <= pwdata[EN_BIT]; // RULE_01 RULE_02
         end
         index_ff <= nxt_index;
         viol_ff  <= nxt_viol;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Trim registers, factory values taken at reset
   always_ff @(posedge clk) begin
      if (srst) begin
         trim_ff <= fuse_trim; // RULE_08 RULE_09 RULE_11
      end else if (ce) begin
         if (wr_done && hit_gain_a) begin
            trim_ff.gain_a <= pwdata[7:0]; // RULE_08
         end
         if (wr_done && hit_gain_b) begin
            trim_ff.gain_b <= pwdata[7:0]; // RULE_09
         end
         if (wr_done && hit_ref) begin
            trim_ff.ref_adj <= pwdata[REF_W-1:0]; // RULE_11
         end
      end
   end

   assign trim_out = trim_ff;

   //////////////////////////////////////////////////////////////////////////
   // Restore path toward the calibration engine
   cst_word_s push_word;
   assign push_word = {index_ff, pwdata[7:0]};

   cst_fifo #(
      .WIDTH ($bits(cst_word_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .in_valid  (cal_wr), // RULE_04
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (fifo_empty_n),
      .out_ready (cal_word_ready),
      .out_data  (fifo_out)
   );

   assign cal_word_valid = fifo_empty_n;
   assign cal_word       = cst_word_s'(fifo_out);

   //////////////////////////////////////////////////////////////////////////
   // Assertions
   a_port_gated_off : assert property (@(posedge clk) disable iff (srst) // RULE_01
      (xfer_done && hit_cal && !port_en_ff && !en_set) |=> (index_ff == $past(index_ff)))
      else $error("disabled port moved the index");

   a_rd_req_enabled : assert property (@(posedge clk) disable iff (srst) // RULE_01
      cal_rd_req |-> port_en_ff)
      else $error("calibration read requested while port disabled");

   a_rd_word_returned : assert property (@(posedge clk) disable iff (srst) // RULE_03
      (ce && cal_rd_req && cal_rd_valid) |=> (in_done && prdata == {24'h000000, $past(cal_rd_data)}))
      else $error("returned calibration word not presented");

   a_index_advance : assert property (@(posedge clk) disable iff (srst) // RULE_12
      (cal_done && index_ff != INDEX_LAST) |=> (index_ff == $past(index_ff) + 10'h001))
      else $error("index did not advance on port access");

   a_index_wrap : assert property (@(posedge clk) disable iff (srst) // RULE_07
      (cal_done && index_ff == INDEX_LAST) |=> (index_ff == INDEX_RST))
      else $error("index did not wrap after last word");

   a_index_restart : assert property (@(posedge clk) disable iff (srst) // RULE_12
      en_set |=> (index_ff == INDEX_RST && port_en_ff))
      else $error("enable did not restart the index");

   a_wr_word_pushed : assert property (@(posedge clk) disable iff (srst) // RULE_04
      (cal_wr && !fifo_empty_n) |=> (fifo_empty_n && cal_word.data == 8'($past(pwdata))
         && cal_word.index == $past(index_ff)))
      else $error("written calibration word not queued");

   a_stream_target : assert property (@(posedge clk) disable iff (srst) // RULE_05
      (cal_done ##1 !cal_done ##[1:2] cal_done) |=>
         (index_ff == INDEX_RST || index_ff == $past(index_ff) + 10'h001))
      else $error("streamed access missed the port");

   a_misuse_flag : assert property (@(posedge clk) disable iff (srst) // RULE_06
      (cal_done && !calibration_halted_flag) |=> viol_ff)
      else $error("access during running calibration not flagged");

   a_gain_a_write : assert property (@(posedge clk) disable iff (srst) // RULE_08
      (wr_done && hit_gain_a) |=> (trim_out.gain_a == 8'($past(pwdata))))
      else $error("gain A write lost");

   a_gain_b_write : assert property (@(posedge clk) disable iff (srst) // RULE_09
      (wr_done && hit_gain_b) |=> (trim_out.gain_b == 8'($past(pwdata))))
      else $error("gain B write lost");

   a_ref_reserved : assert property (@(posedge clk) disable iff (srst) // RULE_11
      (ce && psel && !penable && state_ff == ST_IDLE && hit_ref && !pwrite) |=>
         (prdata[31:REF_W] == '0 && prdata[REF_W-1:0] == trim_ff.ref_adj))
      else $error("reference trim readback wrong");

   a_port_off_zero : assert property (@(posedge clk) disable iff (srst) // RULE_01
      (xfer_done && hit_cal && !port_en_ff && !pwrite) |-> (prdata == RDATA_RST))
      else $error("disabled port returned data");

   a_rd_req_release : assert property (@(posedge clk) disable iff (srst) // RULE_03
      (ce && cal_rd_req && cal_rd_valid) |=> !cal_rd_req)
      else $error("calibration read request held after reply");

   a_ref_write : assert property (@(posedge clk) disable iff (srst) // RULE_11
      (wr_done && hit_ref) |=> (trim_out.ref_adj == REF_W'($past(pwdata))))
      else $error("reference trim write lost");

   a_misuse_sticky : assert property (@(posedge clk) disable iff (srst) // RULE_06
      (viol_ff && !en_set) |=> viol_ff)
      else $error("misuse flag cleared without enable write");

   a_unmapped_read : assert property (@(posedge clk) disable iff (srst)
      (xfer_done && !mapped && !pwrite) |-> (pslverr && prdata == RDATA_RST))
      else $error("unmapped read not refused");

   a_ce_freeze : assert property (@(posedge clk) disable iff (srst)
      !ce |=> (state_ff == $past(state_ff) && index_ff == $past(index_ff) && trim_ff == $past(trim_ff)))
      else $error("state moved while clock enable low");

   c_port_gated  : cover property (@(posedge clk) disable iff (srst) xfer_done && hit_cal && !port_en_ff);
   c_full_save   : cover property (@(posedge clk) disable iff (srst)
      cal_done && !pwrite && index_ff == INDEX_LAST);
   c_full_restore : cover property (@(posedge clk) disable iff (srst)
      cal_done && pwrite && index_ff == INDEX_LAST);
   c_fifo_stall  : cover property (@(posedge clk) disable iff (srst)
      psel && start_wr && !fifo_in_ready);
   c_misuse      : cover property (@(posedge clk) disable iff (srst) viol_set);

endmodule

// [src/cst_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
module cst_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    count_ff;

   wire push = ce & in_valid & in_ready;
   wire pop  = ce & out_valid & out_ready;

   assign in_ready  = (count_ff != CNT_FULL);
   assign out_valid = (count_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : PW'(wr_ptr_ff + 1'b1);
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : PW'(rd_ptr_ff + 1'b1);
         end
         if (push != pop) begin
            count_ff <= push ? CW'(count_ff + 1'b1) : CW'(count_ff - 1'b1);
         end
      end
   end

   a_fifo_no_overflow : assert property (@(posedge clk) disable iff (srst)
      (push && !pop) |=> (count_ff == $past(count_ff) + 1'b1 && count_ff <= CNT_FULL))
      else $error("fifo count lost a pushed word");

endmodule

// [verif/cst_calib_regs_tb_top.sv]
// Self-checking APB testbench for the calibration store and trim register bank
module cst_calib_regs_tb_top
   import cst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk = 1'b0;
   logic                srst = 1'b1;
   logic                ce = 1'b1;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [ADDR_W-1:0]   paddr = '0;
   logic [DATA_W-1:0]   pwdata = '0;
   logic [DATA_W-1:0]   prdata;
   logic                pready;
   logic                pslverr;
   cst_trim_s           fuse_trim = '{gain_a: 8'h3c, gain_b: 8'hc3, ref_adj: 4'h9};
   cst_trim_s           trim_out;
   logic                halted = 1'b1;
   logic                cal_word_valid;
   logic                cal_word_ready = 1'b1;
   cst_word_s           cal_word;
   logic                cal_rd_req;
   logic [IDX_W-1:0]    cal_rd_index;
   logic                cal_rd_valid = 1'b0;
   logic [7:0]          cal_rd_data = 8'h00;
   int                  failures = 0;
   int                  n_checks = 0;
   int                  rd_wait = 0;
   logic                last_err;
   logic                wr_done;
   logic [DATA_W-1:0]   rv;
   logic [31:0]         exp_q[$];

   always #5 clk = ~clk;

   cst_calib_regs DUT (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_trim(fuse_trim), .trim_out(trim_out), .calibration_halted_flag(halted),
      .cal_word_valid(cal_word_valid), .cal_word_ready(cal_word_ready), .cal_word(cal_word),
      .cal_rd_req(cal_rd_req), .cal_rd_index(cal_rd_index), .cal_rd_valid(cal_rd_valid),
      .cal_rd_data(cal_rd_data));

   function automatic logic [7:0] pat(input int k);
      return k[7:0] ^ 8'h5a;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // APB master: leaves the bus asserted so setups can follow back to back
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv       = prdata;
      last_err = pslverr;
   endtask

   task automatic idle();
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      idle();
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      idle();
   endtask

   task automatic port_wr(input int k);
      exp_q.push_back({14'h0, k[IDX_W-1:0], pat(k)});
      apb(1'b1, 12'h1c4, {24'h0, pat(k)});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Calibration engine stand-in: varied reply delay, restore word checker
   always @(posedge clk) begin
      if (cal_rd_req === 1'b1 && cal_rd_valid !== 1'b1 && rd_wait >= int'(cal_rd_index % 3)) begin
         cal_rd_valid <= 1'b1;
         cal_rd_data  <= pat(int'(cal_rd_index));
         rd_wait      <= 0;
      end else begin
         cal_rd_valid <= 1'b0;
         rd_wait      <= (cal_rd_req === 1'b1) ? rd_wait + 1 : 0;
      end
      if (cal_word_valid === 1'b1 && cal_word_ready === 1'b1) begin
         chk({14'h0, cal_word}, exp_q.pop_front());
      end
   end

   initial begin
      #400000;
      failures++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(32'(trim_out), {12'h0, 8'h3c, 8'hc3, 4'h9});
      rd(12'h1e8); chk(rv, 32'h3c);
      rd(12'h1ec); chk(rv, 32'hc3);
      rd(12'h1f0); chk(rv, 32'h9);
      wr(12'h1e8, 32'ha5);
      wr(12'h1ec, 32'h5a);
      wr(12'h1f0, 32'hff);
      rd(12'h1e8); chk(rv, 32'ha5);
      rd(12'h1ec); chk(rv, 32'h5a);
      rd(12'h1f0); chk(rv, 32'h0f);
      chk(32'(trim_out), {12'h0, 8'ha5, 8'h5a, 4'hf});
      rd(12'h1fc); chk({rv[30:0], last_err}, 32'h1);
      rd(12'h1c4); chk({rv[30:0], last_err}, 32'h0);
      wr(12'h1c4, 32'h77);
      rd(12'h1c8); chk(rv, 32'h0005_0000);
      wr(12'h1c0, 32'h1);
      rd(12'h1c0); chk(rv, 32'h1);
      cal_word_ready <= 1'b0;
      for (int k = 0; k < 4; k++) port_wr(k);
      idle();
      rd(12'h1c8); chk(rv, 32'h0001_0004);
      wr_done = 1'b0;
      fork
         begin
            port_wr(4);
            wr_done = 1'b1;
         end
         begin
            repeat (12) @(posedge clk);
            chk(32'(wr_done), 32'h0);
            cal_word_ready <= 1'b1;
         end
      join
      for (int k = 5; k < CAL_WORDS; k++) port_wr(k);
      idle();
      repeat (8) @(posedge clk);
      chk(exp_q.size(), 0);
      rd(12'h1c8); chk(rv, 32'h0005_0000);
      wr(12'h1c0, 32'h1);
      for (int k = 0; k < CAL_WORDS; k++) begin
         apb(1'b0, 12'h1c4, 32'h0);
         chk(rv, {24'h0, pat(k)});
      end
      idle();
      rd(12'h1c4); rd(12'h1c4); chk(rv, {24'h0, pat(1)});
      wr(12'h1c0, 32'h1);
      rd(12'h1c4); chk(rv, {24'h0, pat(0)});
      halted <= 1'b0;
      rd(12'h1c4); chk(rv, {24'h0, pat(1)});
      rd(12'h1c8); chk(rv, 32'h0006_0002);
      halted <= 1'b1;
      wr(12'h1c0, 32'h0);
      rd(12'h1c4); chk(rv, 32'h0);
      rd(12'h1c8); chk(rv, 32'h0007_0002);
      ce <= 1'b0;
      wr_done = 1'b0;
      fork
         begin
            wr(12'h1ec, 32'h66);
            wr_done = 1'b1;
         end
         begin
            repeat (6) @(posedge clk);
            chk(32'({wr_done, trim_out.gain_b}), 32'h5a);
            ce <= 1'b1;
         end
      join
      rd(12'h1ec); chk(rv, 32'h66);
      wr(12'h1c0, 32'h1);
      rd(12'h1c8); chk(rv, 32'h0005_0000);
      final_report();
   end

endmodule
